/* rtl/dma_defines.svh */
// offsets, control word fields, reset values and timing counts of the dma block
// assumes a 32-bit memory bus and an 8-bit register port address
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH

`define CH_NUM 4
`define EXT_CH_NUM 3

// control word fields
`define CTL_EN 15
`define CTL_LOOP 14
`define CTL_EOF 13
`define CTL_HALT 12
`define CTL_WID_LO 10
`define CTL_DST_LO 8
`define CTL_SRC_LO 6
`define CTL_EXT 5
`define CTL_STAT_LO 0
`define CTL_RST 16'h0000

// register index within a channel, address bits [4:2]
`define REG_CTL 3'h0
`define REG_CNT 3'h1
`define REG_DST 3'h2
`define REG_SRC 3'h3
`define REG_LAR 3'h4
`define REG_STA 3'h5

// descriptor layout, offsets from the list pointer
`define DESC_CTL_OFF 32'h0000_0000
`define DESC_CNT_OFF 32'h0000_0002
`define DESC_DST_OFF 32'h0000_0004
`define DESC_SRC_OFF 32'h0000_0008
`define DESC_LAR_OFF 32'h0000_000c

// address step control and transfer width codes
`define STEP_INC 2'h1
`define STEP_DEC 2'h2
`define WID_BYTE 2'h0
`define WID_WORD 2'h1
`define WID_QUAD 2'h2

// cycles an external request is ignored after an acknowledge
`define ACK_HOLD 3'h5

`endif

/* rtl/dma_pkg.sv */
// types shared by the dma block
// constants live in dma_defines.svh
package dma_pkg;

   typedef enum {ST_IDLE, ST_FETCH, ST_MOVE, ST_CLOSE} state_t;

   typedef logic [1:0] chan_t;

endpackage : dma_pkg

/* rtl/linked_list_dma_channel.sv */
// four channel dma engine with direct and linked list operation
// assumes memory read data one cycle after the read strobe output, no wait states
//
// Summary of operation
// [R1] descriptor: control, count at 02h, destination 04h, source 08h, next pointer 0Ch
// [R2] processor setting the enable bit starts direct operation from channel registers
// [R3] enable bit loaded from a descriptor puts the channel in linked list mode
// [R4] writing the list pointer starts a descriptor fetch into channel registers
// [R5] loop bit set in linked mode suppresses descriptor write back
// [R6] width 00 moves bytes, addresses step by 1
// [R7] width 01 moves 16-bit words, addresses step by 2
// [R8] width 10 moves 32-bit quads, addresses step by 4
// [R9] count drops by one per transfer at any width
// [R10] descriptor fetch loads the count field into the count register
// [R11] after fetch, transfers run until count is zero or end of frame
// [R12] close with bits 00 writes control word back with enable cleared
// [R13] close with bits 01 adds peripheral status, then writes count back
// [R14] close with bits 10 or 11 leaves the descriptor untouched
// [R15] halt bit closes the buffer without fetching the next descriptor
// [R16] after the list pointer updates, fetch restarts at the new descriptor
// [R17] round robin: channel just serviced becomes lowest priority
// [R18] channels 0 to 2 have active-low external request and acknowledge pins
// [R19] external request is held low at least one clock per transfer; the synchroniser only takes a request held low for two clocks
// [R20] burst requester releases request after the last acknowledge
// [R21] one active-low acknowledge pulse per externally requested transfer
`timescale 1ns/100ps
`include "dma_defines.svh"

module linked_list_dma_channel import dma_pkg::*; (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   output logic [31:0] MEM_ADDR_OUT,
   output logic [31:0] MEM_WDATA_OUT,
   output logic MEM_RD_OUT,
   output logic MEM_WR_OUT,
   output logic [1:0] MEM_SIZE_OUT,
   input wire logic [31:0] MEM_RDATA_IN,
   input wire logic [3:0] PERIPH_REQ_IN,
   input wire logic [3:0] PERIPH_EOF_IN,
   input wire logic [15:0] PERIPH_STATUS_IN,
   output logic [3:0] PERIPH_ACK_OUT,
   input wire logic [2:0] EXT_REQ_N_IN,
   output logic [2:0] EXT_ACK_N_OUT,
   output logic [3:0] CH_BUSY_OUT
);

   // channel state
   logic [15:0] ctl_r [`CH_NUM], cnt_r [`CH_NUM];
   logic [31:0] dst_r [`CH_NUM], src_r [`CH_NUM], lar_r [`CH_NUM], desc_r [`CH_NUM];
   logic [2:0] hold_r [`EXT_CH_NUM];
   logic [3:0] lnk_r, fetch_pend_r, close_pend_r;

   // engine state
   state_t state_r;
   chan_t cur_r, last_r;
   logic [2:0] idx_r;
   logic [1:0] ph_r;

   // output flops
   logic [31:0] rdata_r, mem_addr_r, mem_wdata_r;
   logic mem_rd_r, mem_wr_r;
   logic [1:0] mem_size_r;
   logic [3:0] periph_ack_r, busy_r;
   logic [2:0] ext_ack_n_r;

   // external request synchronisers, stored active high
   logic [2:0] ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r;

   // decode
   wire chan_t wr_ch = ADDR_IN[6:5];
   wire logic [2:0] reg_sel = ADDR_IN[4:2];
   wire logic addr_ok = (ADDR_IN[7] == 1'b0) && (ADDR_IN[1:0] == 2'h0);
   wire logic cpu_wr = WR_IN && addr_ok;

   // current channel fields
   wire logic [15:0] cur_ctl = ctl_r[cur_r];
   wire logic [1:0] cur_wid = cur_ctl[`CTL_WID_LO +: 2];
   wire logic [1:0] cur_dstc = cur_ctl[`CTL_DST_LO +: 2];
   wire logic [1:0] cur_srcc = cur_ctl[`CTL_SRC_LO +: 2];
   wire logic [1:0] close_mode = {cur_ctl[`CTL_LOOP], cur_ctl[`CTL_EOF]};
   wire logic [3:0] cur_stat = PERIPH_STATUS_IN[{cur_r, 2'h0} +: 4];
   wire logic cur_ext = cur_ctl[`CTL_EXT] && (cur_r != 2'h3);

   logic [31:0] src_nxt, dst_nxt;
   logic [3:0] ready, req_act;
   chan_t pick, cand;
   logic found;

   // address step per transfer width
   wire logic [31:0] step = (cur_wid == `WID_WORD) ? 32'h0000_0002 : // R7
                            (cur_wid == `WID_QUAD) ? 32'h0000_0004 : 32'h0000_0001; // R6 R8

   // fixed, increment or decrement per address
   assign src_nxt = (cur_srcc == `STEP_INC) ? src_r[cur_r] + step :
                    (cur_srcc == `STEP_DEC) ? src_r[cur_r] - step : src_r[cur_r];
   assign dst_nxt = (cur_dstc == `STEP_INC) ? dst_r[cur_r] + step :
                    (cur_dstc == `STEP_DEC) ? dst_r[cur_r] - step : dst_r[cur_r];

   // descriptor field offsets
   wire logic [31:0] fetch_off = (idx_r == 3'h1) ? `DESC_CNT_OFF : // R1
                                 (idx_r == 3'h2) ? `DESC_DST_OFF :
                                 (idx_r == 3'h3) ? `DESC_SRC_OFF :
                                 (idx_r == 3'h4) ? `DESC_LAR_OFF : `DESC_CTL_OFF;

   // request sources; channel 3 has peripheral requests only
   always_comb begin
      req_act = PERIPH_REQ_IN;
      for (int c = 0; c < `EXT_CH_NUM; c++) begin
         if (ctl_r[c][`CTL_EXT]) begin
            req_act[c] = ext_lvl_r[c] && (hold_r[c] == 3'h0); // R18
         end
      end
   end

   // round robin starting after the last serviced channel
   always_comb begin
      pick = last_r;
      cand = last_r;
      found = 1'b0;
      for (int c = 0; c < `CH_NUM; c++) begin
         ready[c] = fetch_pend_r[c] ||
                    (ctl_r[c][`CTL_EN] && (close_pend_r[c] || req_act[c]));
      end
      for (int k = 1; k <= `CH_NUM; k++) begin
         cand = last_r + 2'(k);
         if (ready[cand] && !found) begin
            pick = cand; // R17
            found = 1'b1;
         end
      end
   end

   wire logic [31:0] sta_word = {29'h0, fetch_pend_r[wr_ch], close_pend_r[wr_ch], lnk_r[wr_ch]};
   wire logic [31:0] reg_mux = (reg_sel == `REG_CTL) ? {16'h0000, ctl_r[wr_ch]} :
                               (reg_sel == `REG_CNT) ? {16'h0000, cnt_r[wr_ch]} :
                               (reg_sel == `REG_DST) ? dst_r[wr_ch] :
                               (reg_sel == `REG_SRC) ? src_r[wr_ch] :
                               (reg_sel == `REG_LAR) ? lar_r[wr_ch] :
                               (reg_sel == `REG_STA) ? sta_word : 32'h0000_0000;

   // a change is taken once the second and third stages agree
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ext_s1_r <= 3'h0;
         ext_s2_r <= 3'h0;
         ext_s3_r <= 3'h0;
         ext_lvl_r <= 3'h0;
      end else begin
         ext_s1_r <= ~EXT_REQ_N_IN;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         for (int c = 0; c < `EXT_CH_NUM; c++) begin
            if (ext_s2_r[c] == ext_s3_r[c]) begin
               ext_lvl_r[c] <= ext_s3_r[c];
            end
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= (RD_IN && addr_ok) ? reg_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         for (int c = 0; c < `CH_NUM; c++) begin
            ctl_r[c] <= `CTL_RST;
            cnt_r[c] <= 16'h0000;
            dst_r[c] <= 32'h0000_0000;
            src_r[c] <= 32'h0000_0000;
            lar_r[c] <= 32'h0000_0000;
            desc_r[c] <= 32'h0000_0000;
         end
         for (int c = 0; c < `EXT_CH_NUM; c++) begin
            hold_r[c] <= 3'h0;
         end
         lnk_r <= 4'h0;
         fetch_pend_r <= 4'h0;
         close_pend_r <= 4'h0;
         state_r <= ST_IDLE;
         cur_r <= 2'h0;
         last_r <= 2'h3;
         idx_r <= 3'h0;
         ph_r <= 2'h0;
         mem_addr_r <= 32'h0000_0000;
         mem_wdata_r <= 32'h0000_0000;
         mem_rd_r <= 1'b0;
         mem_wr_r <= 1'b0;
         mem_size_r <= 2'h0;
         periph_ack_r <= 4'h0;
         ext_ack_n_r <= 3'h7;
         busy_r <= 4'h0;
      end else begin
         mem_rd_r <= 1'b0;
         mem_wr_r <= 1'b0;
         periph_ack_r <= 4'h0;
         ext_ack_n_r <= 3'h7;
         for (int c = 0; c < `EXT_CH_NUM; c++) begin
            // masks the stale request still inside the synchroniser
            if (hold_r[c] != 3'h0) begin
               hold_r[c] <= hold_r[c] - 3'h1;
            end
         end
         case (state_r)
            ST_IDLE: begin
               if (|ready) begin
                  cur_r <= pick;
                  last_r <= pick; // R17
                  idx_r <= 3'h0;
                  ph_r <= 2'h0;
                  if (fetch_pend_r[pick]) begin
                     fetch_pend_r[pick] <= 1'b0;
                     close_pend_r[pick] <= 1'b0;
                     desc_r[pick] <= lar_r[pick]; // R16
                     state_r <= ST_FETCH;
                  end else if (close_pend_r[pick]) begin
                     state_r <= ST_CLOSE;
                  end else begin
                     state_r <= ST_MOVE; // R11
                  end
               end
            end
            ST_FETCH: begin
               case (ph_r)
                  2'h0: begin
                     mem_rd_r <= 1'b1;
                     mem_addr_r <= desc_r[cur_r] + fetch_off; // R1
                     mem_size_r <= (idx_r < 3'h2) ? `WID_WORD : `WID_QUAD;
                     ph_r <= 2'h1;
                  end
                  2'h1: ph_r <= 2'h2;
                  default: begin
                     case (idx_r)
                        3'h0: begin
                           ctl_r[cur_r] <= MEM_RDATA_IN[15:0];
                           lnk_r[cur_r] <= 1'b1; // R3
                        end
                        3'h1: cnt_r[cur_r] <= MEM_RDATA_IN[15:0]; // R10
                        3'h2: dst_r[cur_r] <= MEM_RDATA_IN;
                        3'h3: src_r[cur_r] <= MEM_RDATA_IN;
                        default: lar_r[cur_r] <= MEM_RDATA_IN;
                     endcase
                     ph_r <= 2'h0;
                     idx_r <= idx_r + 3'h1;
                     if (idx_r == 3'h4) begin
                        state_r <= ST_IDLE; // R11
                     end
                  end
               endcase
            end
            ST_MOVE: begin
               case (ph_r)
                  2'h0: begin
                     mem_rd_r <= 1'b1;
                     mem_addr_r <= src_r[cur_r];
                     mem_size_r <= cur_wid; // R6 R7 R8
                     ph_r <= 2'h1;
                  end
                  2'h1: ph_r <= 2'h2;
                  default: begin
                     mem_wr_r <= 1'b1;
                     mem_addr_r <= dst_r[cur_r];
                     mem_wdata_r <= MEM_RDATA_IN;
                     src_r[cur_r] <= src_nxt; // R6 R7 R8
                     dst_r[cur_r] <= dst_nxt; // R6 R7 R8
                     cnt_r[cur_r] <= cnt_r[cur_r] - 16'h0001; // R9
                     if (cur_ext) begin
                        ext_ack_n_r[cur_r] <= 1'b0; // R21
                        hold_r[cur_r] <= `ACK_HOLD; // R20
                     end else begin
                        periph_ack_r[cur_r] <= 1'b1;
                     end
                     // count of 1 here reaches zero with this transfer
                     if (cnt_r[cur_r] == 16'h0001 || (!cur_ext && PERIPH_EOF_IN[cur_r])) begin
                        close_pend_r[cur_r] <= 1'b1; // R11
                     end
                     ph_r <= 2'h0;
                     state_r <= ST_IDLE;
                  end
               endcase
            end
            ST_CLOSE: begin
               idx_r <= idx_r + 3'h1;
               if (!lnk_r[cur_r]) begin
                  ctl_r[cur_r][`CTL_EN] <= 1'b0; // R2
                  close_pend_r[cur_r] <= 1'b0;
                  state_r <= ST_IDLE;
               end else if (idx_r == 3'h0) begin
                  if (close_mode == 2'h0) begin
                     mem_wr_r <= 1'b1; // R12
                     mem_addr_r <= desc_r[cur_r];
                     mem_size_r <= `WID_WORD;
                     mem_wdata_r <= {16'h0000, cur_ctl & ~(16'h0001 << `CTL_EN)};
                  end else if (close_mode == 2'h1) begin
                     mem_wr_r <= 1'b1; // R13
                     mem_addr_r <= desc_r[cur_r];
                     mem_size_r <= `WID_WORD;
                     mem_wdata_r <= {16'h0000, cur_ctl[15:`CTL_EN] & 1'b0,
                                     cur_ctl[`CTL_EN-1:4], cur_stat};
                  end
               end else if (idx_r == 3'h1) begin
                  if (close_mode == 2'h1) begin
                     mem_wr_r <= 1'b1; // R13
                     mem_addr_r <= desc_r[cur_r] + `DESC_CNT_OFF;
                     mem_size_r <= `WID_WORD;
                     mem_wdata_r <= {16'h0000, cnt_r[cur_r]};
                  end
                  // loop set: nothing is written back
               end else begin
                  close_pend_r[cur_r] <= 1'b0; // R5 R14
                  if (cur_ctl[`CTL_HALT]) begin
                     ctl_r[cur_r][`CTL_EN] <= 1'b0; // R15
                  end else begin
                     fetch_pend_r[cur_r] <= 1'b1; // R16
                  end
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
         // processor writes win over engine updates in the same cycle
         if (cpu_wr) begin
            case (reg_sel)
               `REG_CTL: begin
                  ctl_r[wr_ch] <= WDATA_IN[15:0];
                  if (WDATA_IN[`CTL_EN]) begin
                     lnk_r[wr_ch] <= 1'b0; // R2
                     close_pend_r[wr_ch] <= 1'b0;
                  end
               end
               `REG_CNT: cnt_r[wr_ch] <= WDATA_IN[15:0];
               `REG_DST: dst_r[wr_ch] <= WDATA_IN;
               `REG_SRC: src_r[wr_ch] <= WDATA_IN;
               `REG_LAR: begin
                  lar_r[wr_ch] <= WDATA_IN;
                  fetch_pend_r[wr_ch] <= 1'b1; // R4
               end
               default: ;
            endcase
         end
         for (int c = 0; c < `CH_NUM; c++) begin
            busy_r[c] <= ctl_r[c][`CTL_EN] || fetch_pend_r[c];
         end
      end
   end

   assign RDATA_OUT = rdata_r;
   assign MEM_ADDR_OUT = mem_addr_r;
   assign MEM_WDATA_OUT = mem_wdata_r;
   assign MEM_RD_OUT = mem_rd_r;
   assign MEM_WR_OUT = mem_wr_r;
   assign MEM_SIZE_OUT = mem_size_r;
   assign PERIPH_ACK_OUT = periph_ack_r;
   assign EXT_ACK_N_OUT = ext_ack_n_r;
   assign CH_BUSY_OUT = busy_r;

endmodule : linked_list_dma_channel

/* verification/dma_properties.sv */
// port checker for the dma block: strobes, acknowledges, moved data
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/100ps
module dma_properties (
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic RD_IN,
   input wire logic [31:0] RDATA_OUT,
   input wire logic [31:0] MEM_WDATA_OUT,
   input wire logic MEM_RD_OUT,
   input wire logic MEM_WR_OUT,
   input wire logic [1:0] MEM_SIZE_OUT,
   input wire logic [31:0] MEM_RDATA_IN,
   input wire logic [3:0] PERIPH_ACK_OUT,
   input wire logic [2:0] EXT_ACK_N_OUT
);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   logic [31:0] mask;
   logic ack_any;
   assign mask = (MEM_SIZE_OUT == 2'h0) ? 32'h0000_00ff :
                 (MEM_SIZE_OUT == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
   assign ack_any = (PERIPH_ACK_OUT != 4'h0) || (EXT_ACK_N_OUT != 3'h7);
   sequence s_move;
      MEM_RD_OUT ##2 (MEM_WR_OUT && ack_any);
   endsequence
   property p_ack_wr; (PERIPH_ACK_OUT != 4'h0) |-> MEM_WR_OUT; endproperty
   property p_ext_wr; (EXT_ACK_N_OUT != 3'h7) |-> MEM_WR_OUT; endproperty
   property p_ext_pulse; (EXT_ACK_N_OUT != 3'h7) |=> (EXT_ACK_N_OUT == 3'h7); endproperty
   property p_ack_rd; ack_any |-> $past(MEM_RD_OUT, 2); endproperty
   property p_width; s_move |-> (MEM_SIZE_OUT == $past(MEM_SIZE_OUT, 2)); endproperty
   property p_data; s_move |-> (((MEM_WDATA_OUT ^ $past(MEM_RDATA_IN)) & mask) == 32'h0);
   endproperty
   property p_rd_gap; MEM_RD_OUT |=> (!MEM_RD_OUT && !MEM_WR_OUT); endproperty
   property p_rdata_idle; !$past(RD_IN) |-> (RDATA_OUT == 32'h0); endproperty
   a_ack_wr: assert property (p_ack_wr) else $error("peripheral ack without write");
   a_ext_wr: assert property (p_ext_wr) else $error("external ack without write");
   a_ext_pulse: assert property (p_ext_pulse) else $error("external ack too long");
   a_ack_rd: assert property (p_ack_rd) else $error("ack without source read");
   a_width: assert property (p_width) else $error("read and write width differ");
   a_data: assert property (p_data) else $error("moved data differs");
   a_rd_gap: assert property (p_rd_gap) else $error("access right after read");
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule : dma_properties

bind linked_list_dma_channel dma_properties dma_properties_inst (.CORE_CLK_IN, .RST_IN,
   .RD_IN, .RDATA_OUT, .MEM_WDATA_OUT, .MEM_RD_OUT, .MEM_WR_OUT, .MEM_SIZE_OUT,
   .MEM_RDATA_IN, .PERIPH_ACK_OUT, .EXT_ACK_N_OUT);

/* verification/dma_partner.sv */
// memory and external requester model on the far side of the dma block
// assumes no wait states and read data in the cycle after the read strobe
`timescale 1ns/100ps
module dma_partner (
   input wire logic clk_in,
   input wire logic [31:0] mem_addr_in,
   input wire logic [31:0] mem_wdata_in,
   input wire logic mem_rd_in,
   input wire logic mem_wr_in,
   input wire logic [1:0] mem_size_in,
   output logic [31:0] mem_rdata_out,
   input wire logic [2:0] ext_go_in,
   input wire logic [3:0] ext_len_in,
   input wire logic [2:0] ext_ack_n_in,
   output logic [2:0] ext_req_n_out
);
   logic [7:0] mem [bit [31:0]];
   int left [3];
   initial begin
      mem_rdata_out = 32'h0;
      ext_req_n_out = 3'h7;
   end
   task automatic put(input logic [31:0] a, input logic [31:0] v, input int n);
      for (int i = 0; i < n; i++) mem[a + 32'(i)] = v[8*i +: 8];
   endtask : put
   always @(posedge clk_in) begin : step
      logic [31:0] d;
      d = 32'h0;
      for (int i = 0; i < (1 << mem_size_in); i++) begin
         if (mem_rd_in && mem.exists(mem_addr_in + 32'(i))) d[8*i +: 8] = mem[mem_addr_in + 32'(i)];
         if (mem_wr_in) mem[mem_addr_in + 32'(i)] = mem_wdata_in[8*i +: 8];
      end
      // released bus toggles so stale data never looks valid
      mem_rdata_out <= mem_rd_in ? d : ~mem_rdata_out;
      for (int c = 0; c < 3; c++) begin
         if (ext_go_in[c]) begin
            left[c] = ext_len_in;
            ext_req_n_out[c] <= 1'b0;
         end else if (!ext_ack_n_in[c] && left[c] > 0) begin
            left[c]--;
            if (left[c] == 0) ext_req_n_out[c] <= 1'b1;
         end
      end
   end
endmodule : dma_partner

/* verification/linked_list_dma_channel_tb.sv */
// self-checking bench: direct, linked list, external and round robin runs
// assumes the register map and timing given with the dma block
`timescale 1ns/100ps
`include "dma_defines.svh"
module linked_list_dma_channel_tb;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [1:0] s;} wr_t;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_pend = 1'b0, mrd, mwr;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, maddr, mwdata, mrdata;
   logic [1:0] msize;
   logic [3:0] preq = 4'h0, peof = 4'h0, pack, busy, elen = 4'h0;
   logic [15:0] pstat = 16'h0;
   logic [2:0] ereq_n, eack_n, ego = 3'h0;
   wr_t wq [$];
   logic [31:0] rq [$];
   int n_mismatch = 0, checks = 0, acks = 0, pk = 0;
   always #25 clk = ~clk;
   linked_list_dma_channel linked_list_dma_channel_inst (.CORE_CLK_IN(clk), .RST_IN(rst),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
      .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwdata), .MEM_RD_OUT(mrd), .MEM_WR_OUT(mwr),
      .MEM_SIZE_OUT(msize), .MEM_RDATA_IN(mrdata), .PERIPH_REQ_IN(preq),
      .PERIPH_EOF_IN(peof), .PERIPH_STATUS_IN(pstat), .PERIPH_ACK_OUT(pack),
      .EXT_REQ_N_IN(ereq_n), .EXT_ACK_N_OUT(eack_n), .CH_BUSY_OUT(busy));
   dma_partner dma_partner_inst (.clk_in(clk), .mem_addr_in(maddr), .mem_wdata_in(mwdata),
      .mem_rd_in(mrd), .mem_wr_in(mwr), .mem_size_in(msize), .mem_rdata_out(mrdata),
      .ext_go_in(ego), .ext_len_in(elen), .ext_ack_n_in(eack_n), .ext_req_n_out(ereq_n));
   function automatic logic [31:0] msk(input logic [1:0] s);
      return (s == 2'h0) ? 32'h0000_00ff : (s == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
   endfunction : msk
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   always @(posedge clk) begin : watch
      wr_t e;
      if (rd_pend) check(rdata, rq.pop_front());
      rd_pend <= rd;
      if (!eack_n[2]) acks++;
      if (pack[1]) pk++;
      if (mwr) begin
         e = '{32'hffff_ffff, 32'h0, 2'h3};
         if (wq.size() != 0) e = wq.pop_front();
         check(maddr, e.a);
         check(mwdata & msk(e.s), e.d);
         check({30'h0, msize}, {30'h0, e.s});
      end
   end
   task automatic reg_wr(input int ch, input logic [2:0] r, input logic [31:0] v);
      @(posedge clk);
      addr <= {1'b0, 2'(ch), r, 2'b00};
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask : reg_rd
   task automatic wait_idle;
      int n;
      n = 0;
      repeat (4) @(posedge clk);
      while ((busy !== 4'h0 || wq.size() != 0) && n < 3000) begin
         @(posedge clk);
         n++;
      end
      check({28'h0, busy}, 32'h0);
   endtask : wait_idle
   task automatic direct(input int ch, input logic [1:0] w, input int n, input logic x);
      logic [31:0] s, d, v;
      int st;
      st = 1 << w;
      s = 32'h100 + 32'(ch) * 32'h40;
      d = 32'h220 + 32'(ch) * 32'h40;
      for (int k = 0; k < n; k++) begin
         v = $urandom & msk(w);
         dma_partner_inst.put(s + 32'(k * st), v, st);
         wq.push_back('{d - 32'(k * st), v, w});
      end
      reg_wr(ch, `REG_SRC, s);
      reg_wr(ch, `REG_DST, d);
      reg_wr(ch, `REG_CNT, 32'(n));
      reg_wr(ch, `REG_CTL, {16'h0, 1'b1, 3'h0, w, `STEP_DEC, `STEP_INC, x, 5'h0});
   endtask : direct
   task automatic desc(input logic [31:0] l, input logic [1:0] md, input logic h,
                       input logic [1:0] w, input logic [31:0] nx);
      logic [15:0] c;
      logic [31:0] v;
      c = {1'b1, md, h, w, `STEP_INC, `STEP_INC, 1'b0, 5'h0};
      v = $urandom & msk(w);
      dma_partner_inst.put(l, {16'h0, c}, 2);
      dma_partner_inst.put(l + `DESC_CNT_OFF, 32'h1, 2);
      dma_partner_inst.put(l + `DESC_DST_OFF, l + 32'h204, 4);
      dma_partner_inst.put(l + `DESC_SRC_OFF, l + 32'h104, 4);
      dma_partner_inst.put(l + `DESC_LAR_OFF, nx, 4);
      dma_partner_inst.put(l + 32'h104, v, 4);
      wq.push_back('{l + 32'h204, v, w});
      if (md == 2'h0) wq.push_back('{l, {17'h0, c[14:0]}, 2'h1});
      if (md == 2'h1) begin
         wq.push_back('{l, {17'h0, c[14:4], pstat[7:4]}, 2'h1});
         wq.push_back('{l + `DESC_CNT_OFF, 32'h0, 2'h1});
      end
   endtask : desc
   initial begin : watchdog
      repeat (8000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
   initial begin : main
      void'($urandom(32'h3cbe));
      repeat (2) @(posedge clk);
      pstat <= 16'($urandom);
      rst <= 1'b0;
      @(posedge clk);
      check({eack_n, busy, rdata[24:0]}, {3'h7, 29'h0});
      preq <= 4'h1;
      for (int w = 0; w < 3; w++) begin
         direct(0, 2'(w), 2, 1'b0);
         wait_idle();
         reg_rd(8'h04, 32'h0);
      end
      reg_rd(8'h84, 32'h0);
      @(posedge clk) preq <= 4'h2;
      desc(32'h400, 2'h0, 1'b0, 2'h0, 32'h440);
      desc(32'h440, 2'h1, 1'b0, 2'h1, 32'h480);
      desc(32'h480, 2'h2, 1'b0, 2'h2, 32'h4c0);
      desc(32'h4c0, 2'h3, 1'b1, 2'h0, 32'h4c0);
      reg_wr(1, `REG_LAR, 32'h400);
      wait_idle();
      check(32'(pk), 32'h4);
      @(posedge clk) preq <= 4'h0;
      acks = 0;
      direct(2, 2'h2, 3, 1'b1);
      @(posedge clk);
      ego <= 3'h4;
      elen <= 4'h3;
      @(posedge clk) ego <= 3'h0;
      wait_idle();
      check(32'(acks), 32'h3);
      direct(3, 2'h0, 2, 1'b0);
      direct(0, 2'h0, 2, 1'b0);
      wq = {wq[0], wq[2], wq[1], wq[3]};
      @(posedge clk) preq <= 4'h9;
      wait_idle();
      // end of frame on the first transfer closes early
      peof <= 4'h8;
      direct(3, 2'h0, 3, 1'b0);
      void'(wq.pop_back());
      void'(wq.pop_back());
      wait_idle();
      reg_rd(8'h64, 32'h2);
      final_report();
   end
endmodule : linked_list_dma_channel_tb
